// ### t1pe_engine.sv
// t1pe_engine: card-side block framer, checker and acknowledgement engine
// assumes a classic wishbone master and a byte link timed by a slow link clock
`timescale 1ns/10ps
module t1pe_engine #(
  parameter int BUF_DEPTH = 254,
  parameter int ETU_CYCLES = 372,
  parameter int CWT_ETU = 43
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_clk,
  input wire t1pe_pkg::t1pe_rx_t link_rx,
  output t1pe_pkg::t1pe_tx_t link_tx
);
  import t1pe_pkg::*;

  if (BUF_DEPTH < 1 || BUF_DEPTH > 254 || ETU_CYCLES < 2 || CWT_ETU < 2 || CWT_ETU > 255)
  begin : g_bad
    $error("t1pe_engine: unsupported parameter value");
  end

  localparam int ETU_W = $clog2(ETU_CYCLES);

  t1pe_state_t state;
  t1pe_kind_t kind;
  logic [10:0] sy1, sy2, sy3, stab;
  logic lclk_d, lrise, lfall, etu_tick, rx_take, f_done, mute, busy;
  logic [ETU_W-1:0] etu_cnt;
  logic [8:0] rx_idx, rx_end, tx_idx, tx_end;
  logic [7:0] r_pcb, r_len, r_inf0, r_lrc, gap, f_pcb, f_len, f_inf0;
  logic [1:0] f_code, code, err_cnt, ifs_tries;
  logic r_perr, ns_card, nr_exp, rx_ready, rx_more, cmd_err, ifs_fail;
  logic [7:0] t_pcb, t_len, t_inf, li_pcb, li_len, rx_len, ifsd, ifsc, txlen;
  logic [7:0] tx_lrc, tx_cur, tx_chk;
  logic [4:0] gcnt;
  logic [7:0] rx_mem [BUF_DEPTH];
  logic [7:0] tx_mem [BUF_DEPTH];
  logic wb_req, wr, cmd_go, cmd_ok, clr_rx, sreq_give_up, oversize;
  logic [1:0] clr_err;
  logic [31:0] rd_data;

  function automatic logic [7:0] pcb_r(input logic nr, input logic [1:0] rc);
    return {3'b100, nr, 2'b00, rc};
  endfunction : pcb_r

  // ************************************************************
  // link input synchroniser, three stages, change counts on agreement
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
      stab <= '0;
      lclk_d <= 1'b0;
    end else begin
      sy1 <= {link_clk, link_rx.valid, link_rx.perr, link_rx.data};
      sy2 <= sy1;
      sy3 <= sy2;
      stab <= (sy3 & ~(sy2 ^ sy3)) | (stab & (sy2 ^ sy3));
      lclk_d <= stab[10];
    end
  end
  assign lrise = stab[10] & ~lclk_d;
  assign lfall = ~stab[10] & lclk_d;

  // elementary time unit enable, paces guard and gap timing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      etu_cnt <= '0;
      etu_tick <= 1'b0;
    end else begin
      etu_tick <= (etu_cnt == ETU_W'(ETU_CYCLES - 1));
      etu_cnt <= (etu_cnt == ETU_W'(ETU_CYCLES - 1)) ? '0 : etu_cnt + 1'b1;
    end
  end

  // ************************************************************
  // receive framer
  // ************************************************************
  assign rx_take = lrise & stab[9] & (state == ST_RX);
  assign rx_end = {1'b0, r_len} + 9'd3;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_idx <= '0;
      r_pcb <= '0;
      r_len <= '0;
      r_inf0 <= '0;
      r_lrc <= '0;
      r_perr <= 1'b0;
      gap <= '0;
      f_done <= 1'b0;
      f_code <= T1PE_RC_OK;
      f_pcb <= '0;
      f_len <= '0;
      f_inf0 <= '0;
    end else begin
      f_done <= 1'b0;
      if (rx_take) begin
        gap <= '0;
        r_lrc <= r_lrc ^ stab[7:0];
        r_perr <= r_perr | stab[8];
        rx_idx <= rx_idx + 9'd1;
        if (rx_idx == 9'd1) r_pcb <= stab[7:0];
        if (rx_idx == 9'd2) r_len <= stab[7:0];
        if (rx_idx == 9'd3) r_inf0 <= stab[7:0];
        if (rx_idx >= 9'd3 && rx_idx == rx_end) begin // RQ7
          f_done <= 1'b1;
          f_pcb <= r_pcb;
          f_len <= r_len;
          f_inf0 <= r_inf0;
          // whole block including check folds to zero
          f_code <= (r_perr | stab[8] | ((r_lrc ^ stab[7:0]) != 8'h00)) ? T1PE_RC_EDC
                    : T1PE_RC_OK; // RQ1 RQ27
          rx_idx <= '0;
          r_lrc <= '0;
          r_perr <= 1'b0;
        end
      end else if (rx_idx != 9'd0 && etu_tick) begin
        if (gap == 8'(CWT_ETU - 1)) begin // RQ9
          f_done <= 1'b1;
          f_code <= T1PE_RC_OTHER;
          f_pcb <= r_pcb;
          f_len <= r_len;
          rx_idx <= '0;
          r_lrc <= '0;
          r_perr <= 1'b0;
          gap <= '0;
        end else begin
          gap <= gap + 8'd1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rx_take && rx_idx >= 9'd3 && rx_idx < rx_end && rx_idx < 9'(BUF_DEPTH + 3)) begin
      rx_mem[8'(rx_idx - 9'd3)] <= stab[7:0];
    end
  end

  // control byte and length validity
  always_comb begin
    code = T1PE_RC_OTHER; // RQ9
    if (f_code != T1PE_RC_OK) begin
      code = f_code;
    end else if (!f_pcb[7]) begin
      if (f_pcb[4:0] == 5'h00 && f_len <= ifsc) code = T1PE_RC_OK; // RQ22 RQ24
    end else if (f_pcb[7:5] == 3'b100) begin
      if (f_len == 8'h00 && f_pcb[3:0] <= 4'h2) code = T1PE_RC_OK; // RQ24
    end else if (f_pcb[6] && f_pcb[4:0] <= T1PE_S_WTX) begin
      if (f_len == {7'h00, f_pcb[0]}) code = T1PE_RC_OK; // RQ25 RQ23
    end
  end
  assign oversize = (f_code == T1PE_RC_OK) && !f_pcb[7] && f_len > ifsc;
  assign sreq_give_up = (t_pcb[4:0] == T1PE_S_IFS) && (ifs_tries == 2'(T1PE_IFS_TRIES));
  assign cmd_ok = (state == ST_RX) && rx_idx == 9'd0 && !f_done && !mute && !busy
                  && (wb_dat_i[T1PE_CTRL_OP +: 2] != 2'd0 || (txlen <= ifsd
                  && txlen <= 8'(BUF_DEPTH)));

  // ************************************************************
  // protocol control
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RX;
      kind <= K_SRESP;
      t_pcb <= '0;
      t_len <= '0;
      t_inf <= '0;
      li_pcb <= '0;
      li_len <= '0;
      ns_card <= 1'b0;
      nr_exp <= 1'b0;
      err_cnt <= '0;
      ifs_tries <= '0;
      mute <= 1'b0;
      busy <= 1'b0;
      rx_ready <= 1'b0;
      rx_more <= 1'b0;
      rx_len <= '0;
      ifsd <= T1PE_IFS_RST;
      cmd_err <= 1'b0;
      ifs_fail <= 1'b0;
      gcnt <= '0;
      tx_idx <= '0;
      tx_lrc <= '0;
      link_tx <= '0;
    end else begin
      if (clr_rx) rx_ready <= 1'b0;
      if (clr_err[0]) cmd_err <= 1'b0;
      if (clr_err[1]) ifs_fail <= 1'b0;
      unique case (state)
        ST_RX: begin
          // silent card listens only for a clean resynch request
          if (f_done && !(mute && (code != T1PE_RC_OK || f_pcb != 8'hc0))) begin
            if (code != T1PE_RC_OK) begin
              if (err_cnt == 2'(T1PE_ERR_LIMIT - 1)) begin
                mute <= 1'b1; // RQ10
                err_cnt <= '0;
              end else begin
                err_cnt <= err_cnt + 2'd1;
                if (kind == K_SREQ) begin
                  if (sreq_give_up) begin
                    ifs_fail <= 1'b1; // RQ17
                    kind <= K_SRESP;
                  end else begin
                    state <= ST_GUARD; // RQ15
                  end
                end else if (kind == K_R && !oversize) begin
                  state <= ST_GUARD; // RQ14
                end else begin
                  t_pcb <= pcb_r(nr_exp, code); // RQ12 RQ14 RQ15 RQ22
                  t_len <= '0;
                  kind <= K_R;
                  state <= ST_GUARD;
                end
              end
            end else begin
              err_cnt <= '0;
              if (kind == K_SREQ && f_pcb != (t_pcb | T1PE_S_RESP)) begin
                if (sreq_give_up) begin
                  ifs_fail <= 1'b1; // RQ17
                  kind <= K_SRESP;
                end else begin
                  state <= ST_GUARD; // RQ8 RQ15
                end
              end else if (kind == K_SREQ) begin
                kind <= K_SRESP; // RQ5 RQ20
                if (t_pcb[4:0] == T1PE_S_ABORT) busy <= 1'b0;
              end else if (!f_pcb[7]) begin
                if (f_pcb[6] != nr_exp) begin
                  t_pcb <= pcb_r(nr_exp, T1PE_RC_OTHER);
                  t_len <= '0;
                  kind <= K_R;
                  state <= ST_GUARD;
                end else begin
                  nr_exp <= ~nr_exp; // RQ3
                  busy <= 1'b0;
                  rx_ready <= 1'b1;
                  rx_more <= f_pcb[5]; // RQ18
                  rx_len <= f_len;
                  state <= ST_HOLD;
                end
              end else if (!f_pcb[6]) begin
                if (busy && f_pcb[4] == li_pcb[6]) begin
                  t_pcb <= li_pcb; // RQ10
                  t_len <= li_len;
                  kind <= K_I;
                  state <= ST_GUARD;
                end else if (busy && li_pcb[5]) begin
                  busy <= 1'b0; // RQ4
                end else if (kind == K_R) begin
                  state <= ST_GUARD; // RQ14
                end
              end else if (!f_pcb[5]) begin
                t_pcb <= f_pcb | T1PE_S_RESP; // RQ8
                t_len <= f_len;
                t_inf <= f_inf0; // RQ6
                kind <= K_SRESP;
                state <= ST_GUARD;
                if (f_pcb[4:0] == T1PE_S_IFS) ifsd <= f_inf0; // RQ6
                if (f_pcb[4:0] == T1PE_S_RESYNCH) begin
                  ns_card <= 1'b0; // RQ10
                  nr_exp <= 1'b0;
                  busy <= 1'b0;
                  mute <= 1'b0;
                end
                if (f_pcb[4:0] == T1PE_S_ABORT) begin
                  busy <= 1'b0; // RQ20
                  rx_more <= 1'b0;
                end
              end else begin
                t_pcb <= pcb_r(nr_exp, T1PE_RC_OTHER); // RQ9
                t_len <= '0;
                kind <= K_R;
                state <= ST_GUARD;
              end
            end
          end else if (cmd_go && cmd_ok) begin
            state <= ST_GUARD;
            t_inf <= wb_dat_i[T1PE_CTRL_INF +: 8];
            if (wb_dat_i[T1PE_CTRL_OP +: 2] == 2'd0) begin
              // card chain blocks stay within the terminal's field size
              t_pcb <= {1'b0, ns_card, wb_dat_i[T1PE_CTRL_MORE], 5'h00}; // RQ18 RQ21 RQ24
              li_pcb <= {1'b0, ns_card, wb_dat_i[T1PE_CTRL_MORE], 5'h00};
              t_len <= txlen;
              li_len <= txlen;
              ns_card <= ~ns_card;
              busy <= 1'b1;
              kind <= K_I;
            end else begin
              t_pcb <= {6'b110000, wb_dat_i[T1PE_CTRL_OP +: 2]}; // RQ25 RQ5 RQ20
              t_len <= {7'h00, wb_dat_i[T1PE_CTRL_OP]};
              ifs_tries <= '0;
              kind <= K_SREQ;
            end
          end
        end
        ST_HOLD: begin
          if (!rx_ready) begin
            if (rx_more) begin
              t_pcb <= pcb_r(nr_exp, T1PE_RC_OK); // RQ19 RQ4
              t_len <= '0;
              kind <= K_R;
              state <= ST_GUARD;
            end else begin
              state <= ST_RX;
            end
          end
        end
        ST_GUARD: begin
          // guard before turning the line round
          if (etu_tick) begin
            if (gcnt == 5'(T1PE_BGT_ETU - 1)) begin // RQ26
              gcnt <= '0;
              tx_idx <= '0;
              tx_lrc <= '0;
              state <= ST_TX;
              // only size requests are counted, other requests would wrap the counter
              if (kind == K_SREQ && t_pcb[4:0] == T1PE_S_IFS) begin
                ifs_tries <= ifs_tries + 2'd1; // RQ17
              end
            end else begin
              gcnt <= gcnt + 5'd1;
            end
          end
        end
        ST_TX: begin
          if (lfall) begin
            if (tx_idx == tx_end + 9'd1) begin
              link_tx.valid <= 1'b0; // RQ7
              state <= ST_RX;
            end else begin
              link_tx.valid <= 1'b1; // RQ23
              link_tx.data <= tx_cur;
              tx_lrc <= tx_lrc ^ tx_cur; // RQ1 RQ27
              tx_idx <= tx_idx + 9'd1;
            end
          end
        end
      endcase
      if (cmd_go && !cmd_ok) cmd_err <= 1'b1;
    end
  end

  assign tx_end = {1'b0, t_len} + 9'd3;
  always_comb begin
    tx_cur = T1PE_NAD;
    if (tx_idx == 9'd1) tx_cur = t_pcb;
    else if (tx_idx == 9'd2) tx_cur = t_len;
    else if (tx_idx == tx_end) tx_cur = tx_lrc;
    else if (tx_idx > 9'd2) tx_cur = (kind == K_I) ? tx_mem[8'(tx_idx - 9'd3)] : t_inf;
  end

  // ************************************************************
  // wishbone slave, one wait state, unmapped reads give zero
  // ************************************************************
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_req & wb_we_i & wb_sel_i[0];
  assign cmd_go = wr && wb_adr_i == T1PE_REG_CTRL && wb_dat_i[T1PE_CTRL_GO];
  assign clr_rx = wr && wb_adr_i == T1PE_REG_STATUS && wb_dat_i[T1PE_ST_RXRDY];
  assign clr_err = (wr && wb_adr_i == T1PE_REG_STATUS) ?
                   {wb_dat_i[T1PE_ST_IFSFAIL], wb_dat_i[T1PE_ST_CMDERR]} : 2'b00;

  always_comb begin
    rd_data = '0;
    if (wb_adr_i[11:10] == T1PE_WIN_RX) begin
      if (wb_adr_i[9:2] < 8'(BUF_DEPTH)) rd_data = {24'h0, rx_mem[wb_adr_i[9:2]]};
    end else if (wb_adr_i == T1PE_REG_STATUS) begin
      rd_data[T1PE_ST_BUSY] = busy;
      rd_data[T1PE_ST_RXRDY] = rx_ready;
      rd_data[T1PE_ST_RXMORE] = rx_more;
      rd_data[T1PE_ST_MUTE] = mute;
      rd_data[T1PE_ST_CMDERR] = cmd_err;
      rd_data[T1PE_ST_IFSFAIL] = ifs_fail;
      rd_data[T1PE_ST_ACTIVE] = (state != ST_RX);
      rd_data[T1PE_ST_RXLEN +: 8] = rx_len;
      rd_data[T1PE_ST_IFSD +: 8] = ifsd;
    end else if (wb_adr_i == T1PE_REG_IFSC) begin
      rd_data = {24'h0, ifsc};
    end else if (wb_adr_i == T1PE_REG_TXLEN) begin
      rd_data = {24'h0, txlen};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ifsc <= T1PE_IFS_RST;
      txlen <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : '0;
      // a field size of zero or the reserved top value is refused
      if (wr && wb_adr_i == T1PE_REG_IFSC && wb_dat_i[7:0] != 8'h00 && wb_dat_i[7:0] <= T1PE_MAX_INF)
      begin
        ifsc <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == T1PE_REG_TXLEN) txlen <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (wr && wb_adr_i[11:10] == T1PE_WIN_TX && wb_adr_i[9:2] < 8'(BUF_DEPTH)) begin
      tx_mem[wb_adr_i[9:2]] <= wb_dat_i[7:0];
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) tx_chk <= '0;
    else if (state == ST_GUARD) tx_chk <= '0;
    else if (lrise && link_tx.valid) tx_chk <= tx_chk ^ link_tx.data;
  end

  property p_ack_drop;
    @(posedge mclk) disable iff (!arst_n) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");
  property p_edc;
    @(posedge mclk) disable iff (!arst_n) $fell(state == ST_TX) |-> tx_chk == 8'h00;
  endproperty
  a_edc: assert property (p_edc) else $error("sent block does not fold to zero"); // RQ1
  property p_chain_r;
    @(posedge mclk) disable iff (!arst_n) (state == ST_HOLD && !rx_ready && rx_more)
      |=> state == ST_GUARD && t_pcb == {3'b100, nr_exp, 4'h0};
  endproperty
  a_chain_r: assert property (p_chain_r) else $error("chain ack wrong"); // RQ19
  property p_oversize;
    @(posedge mclk) disable iff (!arst_n)
      (state == ST_RX && f_done && !mute && oversize && err_cnt != 2'd2 && kind != K_SREQ)
      |=> t_pcb == {3'b100, $past(nr_exp), 4'h2} && state == ST_GUARD;
  endproperty
  a_oversize: assert property (p_oversize) else $error("oversize not refused"); // RQ22
  property p_ifs_echo;
    @(posedge mclk) disable iff (!arst_n) (state == ST_RX && f_done && !mute
      && code == T1PE_RC_OK && kind != K_SREQ && f_pcb == 8'hc1)
      |=> t_pcb == 8'he1 && t_inf == $past(f_inf0) && ifsd == $past(f_inf0);
  endproperty
  a_ifs_echo: assert property (p_ifs_echo) else $error("size response differs"); // RQ6
  property p_mute;
    @(posedge mclk) disable iff (!arst_n) mute |-> state == ST_RX && !link_tx.valid;
  endproperty
  a_mute: assert property (p_mute) else $error("silent card transmits"); // RQ10
  property p_ifs_tries;
    @(posedge mclk) disable iff (!arst_n) ifs_tries <= 2'(T1PE_IFS_TRIES);
  endproperty
  a_ifs_tries: assert property (p_ifs_tries) else $error("size request over-retried"); // RQ17
  property p_i_ack;
    @(posedge mclk) disable iff (!arst_n) (state == ST_RX && f_done && !mute && kind != K_SREQ
      && code == T1PE_RC_OK && !f_pcb[7] && f_pcb[6] == nr_exp)
      |=> state == ST_HOLD && rx_ready && rx_more == $past(f_pcb[5]) && nr_exp != $past(nr_exp);
  endproperty
  a_i_ack: assert property (p_i_ack) else $error("I-block not accepted"); // RQ3
  property p_half;
    @(posedge mclk) disable iff (!arst_n) state == ST_TX |-> rx_idx == 9'd0;
  endproperty
  a_half: assert property (p_half) else $error("receive during send"); // RQ7
  c_chain: cover property (@(posedge mclk) state == ST_HOLD && rx_more ##1 !rx_ready);
  c_ifs: cover property (@(posedge mclk) state == ST_RX && f_done && f_pcb == 8'hc1);
  c_mute: cover property (@(posedge mclk) $rose(mute));
  c_resend: cover property (@(posedge mclk) state == ST_RX && f_done && kind == K_SREQ);
endmodule : t1pe_engine

// ### t1pe_pkg.sv
// t1pe_pkg: constants, carriers and register map of the card-side block protocol engine
// assumes a character layer beyond the link that moves whole bytes with a parity flag
//
// Functional notes
// (RQ1) every block ends in one check byte; receiver verifies it before acceptance
// (RQ2) terminal's first block is an I-block with sequence 0 or an S-block
// (RQ3) unchained I-block is answered by an I-block, also signalling readiness
// (RQ4) chained I-block is answered by R-block carrying the other sequence number
// (RQ5) card asks waiting extension; terminal answers; new time counts from that answer
// (RQ6) field size request answered with identical information; size holds until next request
// (RQ7) right to send passes after length-announced bytes plus check byte arrived
// (RQ8) every supervisory request gets its matching supervisory response
// (RQ9) parity, check, control, length, sync errors or missing response make blocks invalid
// (RQ10) recovery: retransmit, then resynch response, then card goes silent
// (RQ11) terminal retries receiving at most twice at start before resetting card
// (RQ12) first received block invalid: card answers R-block with sequence 0
// (RQ13) terminal retries at most twice during session before resynch request
// (RQ14) after I-block or R-block, error or timeout brings R-block / resend
// (RQ15) request met by non-response is resent; after response, errors bring R-block
// (RQ16) terminal sends no field size request before acknowledging card's I-block
// (RQ17) card's field size request retried once; after second failure card just receives
// (RQ18) more-data bit is one when next block continues the chain
// (RQ19) chained I-block answered by R-block naming next expected sequence number
// (RQ20) abort request answered by abort response; then R-block may pass turn
// (RQ21) terminal chain blocks carry card's field size; card blocks within terminal's
// (RQ22) received block longer than card field size: R-block with error code 2
// (RQ23) block is address, control, length, 0 to 254 information bytes, check
// (RQ24) I, R control byte coding with sequence, more-data and error code bits
// (RQ25) S control byte: request/response bit and type resynch, size, abort, wait
// (RQ26) waiting time spans last received character to first sent character
// (RQ27) check byte is exclusive-OR of all bytes; whole block folds to zero
package t1pe_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] T1PE_REG_CTRL = 12'h000;
  localparam logic [11:0] T1PE_REG_STATUS = 12'h004;
  localparam logic [11:0] T1PE_REG_IFSC = 12'h008;
  localparam logic [11:0] T1PE_REG_TXLEN = 12'h00c;
  localparam logic [1:0] T1PE_WIN_TX = 2'h1;
  localparam logic [1:0] T1PE_WIN_RX = 2'h2;
  localparam int T1PE_CTRL_GO = 0;
  localparam int T1PE_CTRL_OP = 1;
  localparam int T1PE_CTRL_MORE = 3;
  localparam int T1PE_CTRL_INF = 8;
  localparam int T1PE_ST_BUSY = 0;
  localparam int T1PE_ST_RXRDY = 1;
  localparam int T1PE_ST_RXMORE = 2;
  localparam int T1PE_ST_MUTE = 3;
  localparam int T1PE_ST_CMDERR = 4;
  localparam int T1PE_ST_IFSFAIL = 5;
  localparam int T1PE_ST_ACTIVE = 6;
  localparam int T1PE_ST_RXLEN = 8;
  localparam int T1PE_ST_IFSD = 16;
  localparam logic [7:0] T1PE_IFS_RST = 8'h20;
  // ************************************************************
  // block coding and protocol counts
  // ************************************************************
  localparam logic [7:0] T1PE_MAX_INF = 8'hfe;
  localparam logic [1:0] T1PE_RC_OK = 2'h0;
  localparam logic [1:0] T1PE_RC_EDC = 2'h1;
  localparam logic [1:0] T1PE_RC_OTHER = 2'h2;
  localparam logic [4:0] T1PE_S_RESYNCH = 5'h00;
  localparam logic [4:0] T1PE_S_IFS = 5'h01;
  localparam logic [4:0] T1PE_S_ABORT = 5'h02;
  localparam logic [4:0] T1PE_S_WTX = 5'h03;
  localparam logic [7:0] T1PE_S_RESP = 8'h20;
  localparam logic [7:0] T1PE_NAD = 8'h00;
  localparam int T1PE_BGT_ETU = 22;
  localparam int T1PE_ERR_LIMIT = 3;
  localparam int T1PE_IFS_TRIES = 2;
  typedef enum logic [1:0] {ST_RX, ST_HOLD, ST_GUARD, ST_TX} t1pe_state_t;
  typedef enum logic [1:0] {K_I, K_R, K_SREQ, K_SRESP} t1pe_kind_t;
  typedef struct packed {
    logic valid;
    logic perr;
    logic [7:0] data;
  } t1pe_rx_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } t1pe_tx_t;
endpackage : t1pe_pkg

// ### t1pe_term.sv
// t1pe_term: terminal model that clocks the link, sends blocks and captures card replies
// assumes the card samples bytes at rising link_clk and holds its own bytes a full period
`timescale 1ns/10ps
module t1pe_term
  import t1pe_pkg::*;
(
  output logic link_clk,
  output t1pe_rx_t link_rx,
  input wire t1pe_tx_t link_tx
);
  logic [7:0] got [$];
  // card clock runs free at eight mclk periods; odd phase keeps its edges 12 ns after mclk rising edges
  initial begin
    link_clk = 1'b0;
    link_rx = '0;
    #137;
    forever #200 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    if (link_tx.valid === 1'b1) got.push_back(link_tx.data);
  end
  // caller sends only after the card's valid dropped, keeping half duplex
  task automatic send(input logic [7:0] b [$], input logic bad);
    logic [7:0] edc;
    edc = 8'h00;
    foreach (b[i]) edc ^= b[i];
    b.push_back(edc ^ {7'h00, bad});
    foreach (b[i]) begin
      @(negedge link_clk);
      link_rx <= '{1'b1, 1'b0, b[i]};
    end
    @(negedge link_clk);
    // released line shows the inverse, never a stale byte
    link_rx <= '{1'b0, 1'b0, ~b[b.size()-1]};
  endtask : send
endmodule : t1pe_term

// ### tb.sv
// tb: wishbone and link bench for the card block engine
// assumes t1pe_term on the link and shortened etu counts
`timescale 1ns/10ps
module tb;
  import t1pe_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [49:0] rq = '0;
  logic [31:0] rdat;
  logic ack;
  logic [31:0] q;
  logic link_clk;
  t1pe_rx_t link_rx;
  t1pe_tx_t link_tx;
  int miscompares = 0;
  int tests_run = 0;
  always #25 mclk = ~mclk;
  t1pe_term term (.link_clk(link_clk), .link_rx(link_rx), .link_tx(link_tx));
  t1pe_engine #(.BUF_DEPTH(254), .ETU_CYCLES(4), .CWT_ETU(8)) dut (.mclk(mclk),
    .arst_n(arst_n), .wb_cyc_i(rq[49]), .wb_stb_i(rq[49]), .wb_we_i(rq[48]),
    .wb_sel_i(rq[47:44]), .wb_adr_i(rq[43:32]), .wb_dat_i(rq[31:0]), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link_clk(link_clk), .link_rx(link_rx), .link_tx(link_tx));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    rq <= {1'b1, we, 4'hf, a, d};
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    rq <= '0;
    chk("ack", 1, ack);
    @(posedge mclk);
  endtask : wb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input string nm);
    wb(1'b0, a, 0);
    chk(nm, e, q & m);
  endtask : rd
  task automatic poll();
    do wb(1'b0, T1PE_REG_STATUS, 0); while (q[T1PE_ST_RXRDY] !== 1'b1);
  endtask : poll
  task automatic reply(input logic [7:0] e [$]);
    while (term.got.size() < e.size() || link_tx.valid !== 1'b0) @(posedge mclk);
    chk("reply length", e.size(), term.got.size());
    foreach (e[i]) if (i < term.got.size()) chk("reply byte", e[i], term.got[i]);
    term.got.delete();
  endtask : reply
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    #1000000;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (30) @(posedge mclk);
    rd(T1PE_REG_IFSC, 32'h20, '1, "ifsc reset");
    rd(T1PE_REG_TXLEN, 0, '1, "txlen reset");
    rd(12'h100, 0, '1, "unmapped");
    wb(1'b1, T1PE_REG_IFSC, 1);
    wb(1'b1, T1PE_REG_IFSC, 0);
    rd(T1PE_REG_IFSC, 1, '1, "ifsc write");
    $display("test registers ended");
    term.send('{8'h00, 8'h00, 8'h00}, 1'b1);
    reply('{8'h00, 8'h81, 8'h00, 8'h81});
    term.send('{8'h00, 8'hc1, 8'h01, 8'h30}, 1'b0);
    reply('{8'h00, 8'he1, 8'h01, 8'h30, 8'hd0});
    rd(T1PE_REG_STATUS, 32'h300000, 32'hff0000, "ifsd");
    term.send('{8'h00, 8'h00, 8'h02, 8'haa, 8'hbb}, 1'b0);
    reply('{8'h00, 8'h82, 8'h00, 8'h82});
    $display("test errors ended");
    term.send('{8'h00, 8'h20, 8'h01, 8'hcc}, 1'b0);
    poll();
    rd(T1PE_REG_STATUS, 32'h106, 32'hff06, "chained status");
    wb(1'b1, T1PE_REG_STATUS, 32'h2);
    reply('{8'h00, 8'h90, 8'h00, 8'h90});
    term.send('{8'h00, 8'h40, 8'h01, 8'haa}, 1'b0);
    poll();
    rd(T1PE_REG_STATUS, 32'h102, 32'hff06, "last status");
    rd(12'h800, 32'haa, 32'hff, "rx byte");
    $display("test chain ended");
    wb(1'b1, T1PE_REG_STATUS, 32'h2);
    wb(1'b1, T1PE_REG_CTRL, 32'hfe03);
    reply('{8'h00, 8'hc1, 8'h01, 8'hfe, 8'h3e});
    term.send('{8'h00, 8'he1, 8'h01, 8'hfe}, 1'b1);
    reply('{8'h00, 8'hc1, 8'h01, 8'hfe, 8'h3e});
    term.send('{8'h00, 8'he1, 8'h01, 8'hfe}, 1'b1);
    repeat (40) @(posedge mclk);
    rd(T1PE_REG_STATUS, 32'h20, 32'h3f, "size request given up");
    wb(1'b1, 12'h400, 32'h5a);
    wb(1'b1, T1PE_REG_TXLEN, 32'h1);
    wb(1'b1, T1PE_REG_CTRL, 32'h1);
    reply('{8'h00, 8'h00, 8'h01, 8'h5a, 8'h5b});
    wb(1'b1, T1PE_REG_CTRL, 32'h1);
    rd(T1PE_REG_STATUS, 32'h11, 32'h11, "busy refuses go");
    $display("test card requests ended");
    test_done();
  end
endmodule : tb
